// file: hdl/parallel_io_ports.sv
// Purpose: Nine general purpose I/O ports with direction, open drain,
//          threshold select and alternate function combining.
// Assumes: Pins arrive asynchronously; peripherals are on clk.
// Notes:   Pin drive follows the control state by one clock.
//
// How it works
// RQ1 - Port three has fifteen lines, line fourteen absent.
// RQ2 - Ports zero, one written as two bytes.
// RQ3 - Port five is sixteen input-only lines.
// RQ4 - Ports 2,3,4,6,7,8 have per-pin open drain.
// RQ5 - Open drain drives low only, releases high.
// RQ6 - Every pin sampled each clock, any direction.
// RQ7 - Input pin: write latch, read pin sample.
// RQ8 - Input pin RMW takes pin, stores latch.
// RQ9 - Output pin: driver on, read returns latch.
// RQ10 - Output pin RMW takes latch, changes pin.
// RQ11 - Threshold: one bit per byte port.
// RQ12 - Direction, output mode ignore threshold selection.
// RQ13 - Alternate output drives only when direction output.
// RQ14 - Latch ANDed with alternate data, except PWM.
// RQ15 - All directions are input after reset.
// RQ16 - Output pin feeds latch to alternate input.
// RQ17 - Hardware may switch direction automatically.
// RQ18 - Software sets direction before alternate enable.
// RQ19 - Port four can output segment address.
// RQ20 - One alternate function per line, else GPIO.

`timescale 1ns/1ps
`default_nettype none

module parallel_io_ports
    import pio_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [8:0][15:0] pin_in,
    output logic [8:0][15:0] pin_out,
    output logic [8:0][15:0] pin_oe,
    output logic [8:0][1:0] thr_sel,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic acc_rmw,
    input wire rmw_op_t rmw_op,
    input wire reg_sel_t acc_sel,
    input wire logic [3:0] acc_port,
    input wire logic [1:0] acc_be,
    input wire logic [15:0] acc_wdata,
    output logic [15:0] acc_rdata,
    input wire logic [8:0][15:0] alt_out_data,
    input wire logic [8:0][15:0] alt_is_pwm,
    output logic [8:0][15:0] alt_in,
    input wire logic [8:0][15:0] auto_dir_en,
    input wire logic [8:0][15:0] auto_dir,
    input wire logic seg_en,
    input wire logic [7:0] seg_addr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0][15:0] latch;
        logic [8:0][15:0] dir;
        logic [8:0][15:0] od;
        logic [8:0][15:0] alt_en;
        logic [8:0][1:0] thr;
        logic [8:0][15:0] in_meta;
        logic [8:0][15:0] in_samp;
        logic [8:0][15:0] out;
        logic [8:0][15:0] oe;
        logic [8:0][15:0] alt_in;
        logic [15:0] rdata;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // Next state: sampling, drive, alternate paths and software access.
    always_comb begin
        logic eff_dir;
        logic dat;
        logic [15:0] bemask;
        logic [15:0] src;
        logic [15:0] res;
        logic [15:0] view;
        eff_dir = 1'b0;
        dat = 1'b0;
        bemask = {{8{acc_be[1]}}, {8{acc_be[0]}}};
        src = 16'h0000;
        res = 16'h0000;
        view = 16'h0000;
        nxt_st = st_ff;

        // Two stage pin sampling; only the second stage is used.
        nxt_st.in_meta = pin_in; // RQ6
        nxt_st.in_samp = st_ff.in_meta; // RQ6

        // Pin drive per line.
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
                // Hardware owned direction overrides the register.
                eff_dir = auto_dir_en[p][b] ? auto_dir[p][b] // RQ17
                                            : st_ff.dir[p][b];
                dat = st_ff.latch[p][b];
                if (st_ff.alt_en[p][b]) begin
                    // Latch gates the alternate data except for PWM.
                    dat = alt_is_pwm[p][b] ? alt_out_data[p][b] // RQ14
                        : (st_ff.latch[p][b] & alt_out_data[p][b]);
                end
                if (seg_en && p == int'(SEG_PORT) && b < SEG_W) begin
                    eff_dir = 1'b1; // RQ19
                    dat = seg_addr[b]; // RQ19
                end
                if (!IMPL_MASK[p][b] || p == int'(INPUT_ONLY_PORT)) begin
                    eff_dir = 1'b0; // RQ1 RQ3
                end
                nxt_st.out[p][b] = dat;
                // Open drain releases the pin when driving a one.
                nxt_st.oe[p][b] = eff_dir & // RQ9 RQ13
                    ~(st_ff.od[p][b] & dat); // RQ5
                // Alternate input sees the latch when the direction register selects output.
                // Lines that do not exist always read as zero.
                nxt_st.alt_in[p][b] = IMPL_MASK[p][b] & // RQ1
                    (st_ff.dir[p][b] ? st_ff.latch[p][b] // RQ16
                                     : st_ff.in_samp[p][b]);
            end
        end

        // Software access to the selected port.
        if (acc_port < 4'(NUM_PORTS)) begin
            // Read source: pin for inputs, latch for outputs.
            src = ((st_ff.dir[acc_port] & st_ff.latch[acc_port]) | // RQ9
                   (~st_ff.dir[acc_port] & st_ff.in_samp[acc_port])) // RQ7
                  & IMPL_MASK[acc_port];
            case (rmw_op)
                RMW_AND: res = src & acc_wdata; // RQ8 RQ10
                RMW_OR: res = src | acc_wdata;
                RMW_XOR: res = src ^ acc_wdata;
                default: res = src;
            endcase
            if (!acc_rmw) begin
                res = acc_wdata;
            end
            res = res & IMPL_MASK[acc_port]; // RQ1
            case (acc_sel)
                SEL_DATA: view = src;
                SEL_DIR: view = st_ff.dir[acc_port];
                SEL_OD: view = st_ff.od[acc_port];
                SEL_ALT: view = st_ff.alt_en[acc_port];
                SEL_THR: view = {14'h0000, st_ff.thr[acc_port]};
                default: view = 16'h0000;
            endcase
            if (acc_rd) begin
                nxt_st.rdata = view;
            end
            if (acc_wr || acc_rmw) begin
                // Each byte lane written on its own; threshold writes ignore acc_be.
                case (acc_sel)
                    SEL_DATA: nxt_st.latch[acc_port] = // RQ2 RQ7
                        (st_ff.latch[acc_port] & ~bemask) | (res & bemask);
                    SEL_DIR: if (acc_port != INPUT_ONLY_PORT) begin
                        nxt_st.dir[acc_port] =
                            (st_ff.dir[acc_port] & ~bemask) |
                            (res & bemask);
                    end
                    SEL_OD: if (OD_CAPABLE[acc_port]) begin
                        nxt_st.od[acc_port] = // RQ4
                            (st_ff.od[acc_port] & ~bemask) |
                            (res & bemask);
                    end
                    SEL_ALT: nxt_st.alt_en[acc_port] = // RQ20
                        (st_ff.alt_en[acc_port] & ~bemask) | (res & bemask);
                    SEL_THR: begin
                        // Threshold only goes to the pads.
                        nxt_st.thr[acc_port][0] = res[0]; // RQ11 RQ12
                        nxt_st.thr[acc_port][1] =
                            res[1] & THR_TWO_BITS[acc_port]; // RQ11
                    end
                    default: nxt_st.latch = st_ff.latch;
                endcase
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.dir <= {NUM_PORTS{RST_DIR}}; // RQ15
            st_ff.latch <= {NUM_PORTS{RST_LATCH}};
            st_ff.od <= {NUM_PORTS{RST_OD}};
            st_ff.alt_en <= {NUM_PORTS{RST_ALT}};
            st_ff.thr <= {NUM_PORTS{RST_THR}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops.
    assign pin_out = st_ff.out;
    assign pin_oe = st_ff.oe;
    assign alt_in = st_ff.alt_in;
    assign thr_sel = st_ff.thr;
    assign acc_rdata = st_ff.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic dir_written_ff;

    // Tracks whether any direction write has happened since reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dir_written_ff <= 1'b0;
        end else if ((acc_wr || acc_rmw) && acc_sel == SEL_DIR) begin
            dir_written_ff <= 1'b1;
        end
    end

    a_reset_dir_input: assert property ( // RQ15
        !dir_written_ff |-> st_ff.dir == '0)
        else $error("direction not input before first write");
    a_input_only_port: assert property ( // RQ3
        pin_oe[5] == 16'h0000)
        else $error("input only port drives");
    a_missing_line: assert property ( // RQ1
        !pin_oe[3][14] && !st_ff.latch[3][14])
        else $error("unimplemented line active");
    a_od_release_high: assert property ( // RQ5
        st_ff.od[2][0] && !auto_dir_en[2][0] ##1 pin_out[2][0]
        |-> !pin_oe[2][0])
        else $error("open drain drove high");
    a_read_pin_sample: assert property ( // RQ7
        acc_rd && acc_sel == SEL_DATA && acc_port == 4'h2 &&
        st_ff.dir[2] == 16'h0000
        |=> acc_rdata == $past(st_ff.in_samp[2]))
        else $error("input read not from pin");
    a_read_out_latch: assert property ( // RQ9
        acc_rd && acc_sel == SEL_DATA && acc_port == 4'h2 &&
        st_ff.dir[2] == 16'hFFFF
        |=> acc_rdata == $past(st_ff.latch[2]))
        else $error("output read not from latch");
    a_write_to_latch: assert property ( // RQ7
        acc_wr && !acc_rmw && acc_sel == SEL_DATA && acc_port == 4'h0 &&
        acc_be == 2'h3 |=> st_ff.latch[0] == $past(acc_wdata))
        else $error("write did not reach latch");
    a_alt_needs_dir: assert property ( // RQ13
        st_ff.alt_en[7][0] && !st_ff.dir[7][0] && !auto_dir_en[7][0]
        |=> !pin_oe[7][0])
        else $error("alternate output drove input pin");
    a_alt_in_loop: assert property ( // RQ16
        st_ff.dir[2][3] && $stable(st_ff.latch[2][3])
        |=> alt_in[2][3] == $past(st_ff.latch[2][3]))
        else $error("alternate input missed latch");

    // ------------------------------------------------------------
    // Checks on drive and access paths
    // ------------------------------------------------------------

    // Open drain selects never stick on ports without the feature.
    a_od_refused: assert property ( // RQ4
        st_ff.od[0] == 16'h0000 && st_ff.od[1] == 16'h0000 &&
        st_ff.od[5] == 16'h0000)
        else $error("open drain set on port without it");

    // Byte ports keep their upper threshold bit clear.
    a_thr_one_bit: assert property ( // RQ11
        !st_ff.thr[0][1] && !st_ff.thr[1][1] && !st_ff.thr[4][1] &&
        !st_ff.thr[6][1] && !st_ff.thr[7][1] && !st_ff.thr[8][1])
        else $error("second threshold bit on byte port");

    // Read data only moves on a read strobe.
    a_rdata_holds: assert property ( // RQ7
        !acc_rd |=> $stable(acc_rdata))
        else $error("read data changed without read");

    // Input pin read-modify-write starts from the pin sample.
    a_rmw_from_pin: assert property ( // RQ8
        acc_rmw && rmw_op == RMW_OR && acc_sel == SEL_DATA &&
        acc_port == 4'h2 && acc_be == 2'h3 && st_ff.dir[2] == 16'h0000
        |=> st_ff.latch[2] == ($past(st_ff.in_samp[2]) | $past(acc_wdata)))
        else $error("input rmw not from pin");

    // Output pin read-modify-write starts from the latch.
    a_rmw_from_latch: assert property ( // RQ10
        acc_rmw && rmw_op == RMW_XOR && acc_sel == SEL_DATA &&
        acc_port == 4'h2 && acc_be == 2'h3 && st_ff.dir[2] == 16'hFFFF
        |=> st_ff.latch[2] == ($past(st_ff.latch[2]) ^ $past(acc_wdata)))
        else $error("output rmw not from latch");

    // Alternate data is gated by the latch on ordinary lines.
    a_alt_and_latch: assert property ( // RQ14
        st_ff.alt_en[7][0] && !alt_is_pwm[7][0]
        |=> pin_out[7][0] == ($past(st_ff.latch[7][0]) &
                              $past(alt_out_data[7][0])))
        else $error("alternate data not gated by latch");

    // PWM lines pass the alternate data straight through.
    a_pwm_bypass: assert property ( // RQ14
        st_ff.alt_en[7][0] && alt_is_pwm[7][0]
        |=> pin_out[7][0] == $past(alt_out_data[7][0]))
        else $error("pwm line gated by latch");

    // Hardware owned direction decides the driver.
    a_auto_dir: assert property ( // RQ17
        auto_dir_en[6][0] && !st_ff.od[6][0]
        |=> pin_oe[6][0] == $past(auto_dir[6][0]))
        else $error("automatic direction ignored");

    // Segment address takes over all eight lines of port four.
    a_seg_drive: assert property ( // RQ19
        seg_en && st_ff.od[4][7:0] == 8'h00
        |=> pin_oe[4][7:0] == 8'hFF && pin_out[4][7:0] == $past(seg_addr))
        else $error("segment address not driven");

endmodule

`default_nettype wire

// file: hdl/pio_pkg.sv
// Purpose: Shared constants and types for the parallel port block.
// Assumes: Nine ports, each held in a 16-bit slot, one clock domain.
// Notes:   Slots wider than a port carry zero in the unused bits.

package pio_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 9;
    localparam int PORT_W = 16;
    localparam logic [3:0] INPUT_ONLY_PORT = 4'h5;
    localparam logic [3:0] SEG_PORT = 4'h4;
    localparam int SEG_W = 8;

    // Implemented lines per port; port 3 lacks line 14.
    localparam logic [8:0][15:0] IMPL_MASK = {
        16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
        16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

    // Ports whose drivers can run open drain: 2, 3, 4, 6, 7 and 8.
    localparam logic [8:0] OD_CAPABLE = 9'h1DC;

    // Ports with two threshold bits (one per byte): 2, 3 and 5.
    localparam logic [8:0] THR_TWO_BITS = 9'h02C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_DIR = 16'h0000;
    localparam logic [15:0] RST_LATCH = 16'h0000;
    localparam logic [15:0] RST_OD = 16'h0000;
    localparam logic [15:0] RST_ALT = 16'h0000;
    localparam logic [1:0] RST_THR = 2'h0;

    // ------------------------------------------------------------
    // Access selectors
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_DATA,
        SEL_DIR,
        SEL_OD,
        SEL_ALT,
        SEL_THR
    } reg_sel_t;

    typedef enum logic [1:0] {
        RMW_AND,
        RMW_OR,
        RMW_XOR
    } rmw_op_t;

endpackage

// file: dv/pin_world.sv
// Purpose: Model of the circuitry wired outside the port pins.
// Assumes: Every line carries a weak pull-up to the high level.
// Notes:   Outside drive only matters where the device lets go.

`timescale 1ns/1ps
`default_nettype none

module pin_world (
    input wire logic [8:0][15:0] pin_out,
    input wire logic [8:0][15:0] pin_oe,
    input wire logic [8:0][15:0] ext_en,
    input wire logic [8:0][15:0] ext_val,
    output logic [8:0][15:0] pin_in
);
    // A line shows the device drive, else the outside drive, else high.
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
            | (~pin_oe & ~ext_en);
    end
endmodule

`default_nettype wire

// file: dv/parallel_io_ports_tb.sv
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Outside circuitry is the pin_world model with pull-ups.
// Notes:   Each access is followed by four settling cycles.

`timescale 1ns/1ps
`default_nettype none

module parallel_io_ports_tb;
    import pio_pkg::*;
    localparam logic [2:0] WR = 3'h4;
    localparam logic [2:0] RD = 3'h2;
    localparam logic [2:0] MW = 3'h1;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [8:0][15:0] pin_in, pin_out, pin_oe, alt_in;
    logic [8:0][15:0] alt_out_data = '0, alt_is_pwm = '0;
    logic [8:0][15:0] auto_dir_en = '0, auto_dir = '0;
    logic [8:0][15:0] ext_en = '0, ext_val = '0;
    logic [8:0][1:0] thr_sel;
    logic acc_wr = 1'b0, acc_rd = 1'b0, acc_rmw = 1'b0, seg_en = 1'b0;
    rmw_op_t rmw_op = RMW_OR;
    reg_sel_t acc_sel = SEL_DATA;
    logic [3:0] acc_port = 4'h0;
    logic [1:0] acc_be = 2'h3;
    logic [15:0] acc_wdata = 16'h0000, acc_rdata;
    logic [7:0] seg_addr = 8'h00;
    int err_total = 0, n_compared = 0, cyc = 0;

    // Clock of 25 ns period and the cycle ceiling.
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end

    parallel_io_ports i_dut (.clk(clk), .nrst(nrst), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .thr_sel(thr_sel),
        .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rmw(acc_rmw),
        .rmw_op(rmw_op), .acc_sel(acc_sel), .acc_port(acc_port),
        .acc_be(acc_be), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .alt_out_data(alt_out_data), .alt_is_pwm(alt_is_pwm),
        .alt_in(alt_in), .auto_dir_en(auto_dir_en), .auto_dir(auto_dir),
        .seg_en(seg_en), .seg_addr(seg_addr));
    pin_world i_world (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    // One access of kind k, strobe high for one cycle, then settling.
    task automatic acc(input logic [2:0] k, input reg_sel_t s,
        input logic [3:0] p, input logic [15:0] d);
        @(posedge clk);
        {acc_wr, acc_rd, acc_rmw} <= k;
        acc_sel <= s;
        acc_port <= p;
        acc_wdata <= d;
        @(posedge clk);
        {acc_wr, acc_rd, acc_rmw} <= 3'h0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic idle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        for (int i = 0; i < 9; i++) begin
            chk(pin_oe[i], 16'h0000);
        end
        $display("test reset done");
    endtask

    // Port 2: input and output access, plain and read-modify-write.
    task automatic t_access;
        @(posedge clk);
        ext_en[2] <= 16'hFFFF;
        ext_val[2] <= 16'h1234;
        acc(WR, SEL_DATA, 4'h2, 16'h00AA);
        acc(RD, SEL_DATA, 4'h2, 16'h0000);
        chk(acc_rdata, 16'h1234);
        chk(pin_oe[2], 16'h0000);
        acc(MW, SEL_DATA, 4'h2, 16'h0001);
        @(posedge clk);
        ext_en[2] <= 16'h0000;
        acc(WR, SEL_DIR, 4'h2, 16'hFFFF);
        chk(pin_out[2], 16'h1235);
        chk(pin_oe[2], 16'hFFFF);
        @(posedge clk);
        rmw_op <= RMW_XOR;
        acc(MW, SEL_DATA, 4'h2, 16'h00FF);
        chk(pin_out[2], 16'h12CA);
        acc(RD, SEL_DATA, 4'h2, 16'h0000);
        chk(acc_rdata, 16'h12CA);
        acc(WR, SEL_THR, 4'h2, 16'h0003);
        chk(thr_sel[2], 2'h3);
        chk(pin_oe[2], 16'hFFFF);
        acc(WR, SEL_OD, 4'h2, 16'h00FF);
        chk(pin_oe[2], 16'hFF35);
        $display("test access done");
    endtask

    // Port shapes, byte halves and refused writes.
    task automatic t_shape;
        acc(WR, SEL_DIR, 4'h3, 16'hFFFF);
        chk(pin_oe[3], 16'hBFFF);
        acc(WR, SEL_DIR, 4'h5, 16'hFFFF);
        chk(pin_oe[5], 16'h0000);
        acc(WR, SEL_DATA, 4'h0, 16'hFFFF);
        acc(WR, SEL_DIR, 4'h0, 16'hFFFF);
        acc(WR, SEL_OD, 4'h0, 16'hFFFF);
        chk(pin_oe[0], 16'hFFFF);
        @(posedge clk);
        acc_be <= 2'h2;
        acc(WR, SEL_DIR, 4'h1, 16'hFFFF);
        chk(pin_oe[1], 16'hFF00);
        @(posedge clk);
        acc_be <= 2'h3;
        acc(WR, SEL_THR, 4'h4, 16'h0003);
        chk(thr_sel[4], 2'h1);
        $display("test shape done");
    endtask

    // Port 7 alternate output combining and alternate input.
    task automatic t_alt;
        @(posedge clk);
        alt_out_data[7] <= 16'h005A;
        acc(WR, SEL_DATA, 4'h7, 16'h00FF);
        acc(WR, SEL_ALT, 4'h7, 16'h00FF);
        chk(pin_oe[7], 16'h0000);
        acc(WR, SEL_DIR, 4'h7, 16'h00FF);
        chk(pin_out[7], 16'h005A);
        acc(WR, SEL_DATA, 4'h7, 16'h00F0);
        chk(pin_out[7], 16'h0050);
        chk(alt_in[7], 16'h00F0);
        @(posedge clk);
        alt_is_pwm[7] <= 16'h00FF;
        idle();
        chk(pin_out[7], 16'h005A);
        $display("test alternate done");
    endtask

    // Hardware direction override and segment address output.
    task automatic t_auto;
        @(posedge clk);
        auto_dir_en[6] <= 16'h00FF;
        auto_dir[6] <= 16'h000F;
        seg_en <= 1'b1;
        seg_addr <= 8'hA5;
        idle();
        chk(pin_oe[6], 16'h000F);
        chk(pin_oe[4], 16'h00FF);
        chk(pin_out[4], 16'h00A5);
        $display("test override done");
    endtask

    task automatic give_verdict;
        $display("compared %0d wrong %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset for eight cycles, then the tests in turn.
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        idle();
        t_reset();
        t_access();
        t_shape();
        t_alt();
        t_auto();
        give_verdict();
    end
endmodule

`default_nettype wire
